// ---- design/zcdg_defs.svh ----
// Purpose: timing, level and width constants for zero crossing drive gating
// Assumes: 40 MHz system clock
// Notes: comparator levels are in millivolts and name the analogue trips
`ifndef ZCDG_DEFS_SVH
`define ZCDG_DEFS_SVH

`define ZCDG_CLK_MHZ 40
`define ZCDG_MAIN_START_MV 120
`define ZCDG_MAIN_STOP_MV 100
`define ZCDG_RECT_START_MV 200
`define ZCDG_RECT_STOP_MV 180
`define ZCDG_COMP_START_MV 220
`define ZCDG_COMP_STOP_MV 200
`define ZCDG_OL_ON0_US 1
`define ZCDG_OL_ON1_US 2
`define ZCDG_OL_ON2_US 4
`define ZCDG_OL_ON3_US 6
`define ZCDG_OL_OFF_MULT 3
`define ZCDG_OL_PULSES 4
`define ZCDG_POL_FILTER_US 10
`define ZCDG_CNT_W 12
`define ZCDG_CHK_W 16

`endif

// ---- design/zcdg_pkg.sv ----
// Purpose: types shared by the zero crossing drive gating block
// Assumes: nothing beyond the defs header
// Notes: holds types only
package zcdg_pkg;
  typedef enum logic {
    ZCDG_MODE_FIXED,
    ZCDG_MODE_MULTI
  } zcdg_mode_e;
  typedef enum logic [1:0] {
    ZCDG_OL_IDLE,
    ZCDG_OL_ON,
    ZCDG_OL_OFF
  } zcdg_ol_e;
endpackage : zcdg_pkg

// ---- design/zcdg_hyst.sv ----
// Purpose: one hysteretic enable from a start and a stop comparator flag
// Assumes: flags already synchronised to clock_i
// Notes: start and stop flags are true while the line is above each level
`timescale 1ns/1ps
module zcdg_hyst (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic clear_i,
  input wire logic above_start_i,
  input wire logic above_stop_i,
  output logic enable_o
);
  logic en_q;
  // --------------------------------------------------------------
  // hysteresis latch
  // --------------------------------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (rst_i || clear_i)
      en_q <= 1'b0;
    else if (!en_q && above_start_i)
      en_q <= 1'b1;
    else if (en_q && !above_stop_i)
      en_q <= 1'b0;
  end
  assign enable_o = en_q;

  hold_on_a : assert property (@(posedge clock_i) disable iff (rst_i)
    (en_q && above_stop_i && !clear_i) |=> en_q)
    else $error("enable dropped while above stop level");
  hold_off_a : assert property (@(posedge clock_i) disable iff (rst_i)
    (!en_q && !above_start_i) |=> !en_q)
    else $error("enable rose while below start level");
endmodule : zcdg_hyst

// ---- design/zcdg_polf.sv ----
// Purpose: polarity filter; output follows input held longer than filter
// Assumes: raw polarity already synchronised
// Notes: any shorter excursion restarts the timer
`timescale 1ns/1ps
`include "zcdg_defs.svh"
module zcdg_polf #(
  parameter int FILT_CYC = 400
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic raw_i,
  output logic filt_o
);
  initial
  begin
    if (FILT_CYC < 1 || FILT_CYC >= (1 << `ZCDG_CNT_W))
      $error("filter count out of range");
  end
  logic [`ZCDG_CNT_W-1:0] cnt_q;
  logic filt_q;
  // --------------------------------------------------------------
  // filter timer
  // --------------------------------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      cnt_q <= '0;
    else if (raw_i == filt_q)
      cnt_q <= '0;
    else if (cnt_q != FILT_CYC[`ZCDG_CNT_W-1:0])
      cnt_q <= cnt_q + 1'b1;
  end
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      filt_q <= 1'b0;
    else if (raw_i != filt_q && cnt_q == FILT_CYC[`ZCDG_CNT_W-1:0])
      filt_q <= raw_i;
  end
  assign filt_o = filt_q;

  short_glitch_a : assert property (@(posedge clock_i) disable iff (rst_i)
    (raw_i == filt_q) |=> (cnt_q == 12'h000))
    else $error("filter timer not restarted");
endmodule : zcdg_polf

// ---- design/zcdg_top.sv ----
// Purpose: zero crossing gating of six drive outputs with open loop pulses
// Assumes: comparator flags and raw polarity arrive from the analogue side
// Notes: duty modulation itself is outside; duty_req_i is its pulse train
`timescale 1ns/1ps
`include "zcdg_defs.svh"
module zcdg_top #(
  parameter int CLK_MHZ = `ZCDG_CLK_MHZ,
  parameter int POL_FILTER_US = `ZCDG_POL_FILTER_US
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic mode_multi_i,
  input wire logic polarity_raw_i,
  input wire logic main_above_start_i,
  input wire logic main_above_stop_i,
  input wire logic rect_above_start_i,
  input wire logic rect_above_stop_i,
  input wire logic comp_above_start_i,
  input wire logic comp_above_stop_i,
  input wire logic duty_req_i,
  output logic fast_leg_low_drive_o,
  output logic fast_leg_high_drive_o,
  output logic fast_leg_low_sync_o,
  output logic fast_leg_high_sync_o,
  output logic slow_leg_low_switch_o,
  output logic slow_leg_high_switch_o,
  output logic sense_blank_o,
  output logic positive_half_o,
  output logic open_loop_busy_o,
  output logic multi_mode_o
);
  localparam int FILT_CYC = POL_FILTER_US * CLK_MHZ;
  localparam int UNIT_CYC = CLK_MHZ;
  localparam int ON0_CYC = `ZCDG_OL_ON0_US * UNIT_CYC;
  localparam int OFF0_CYC = ON0_CYC * `ZCDG_OL_OFF_MULT;
  // whole sequence: every on time plus its off time
  localparam int OL_TOTAL = (`ZCDG_OL_ON0_US + `ZCDG_OL_ON1_US
    + `ZCDG_OL_ON2_US + `ZCDG_OL_ON3_US) * UNIT_CYC
    * (`ZCDG_OL_OFF_MULT + 1);
  initial
  begin
    if (CLK_MHZ < 1 || UNIT_CYC * `ZCDG_OL_ON3_US * `ZCDG_OL_OFF_MULT
        >= (1 << `ZCDG_CNT_W))
      $error("clock rate unsupported by pulse counter");
    if (OL_TOTAL >= (1 << `ZCDG_CHK_W))
      $error("clock rate unsupported by check counter");
  end

  // --------------------------------------------------------------
  // input synchronisers
  // --------------------------------------------------------------
  logic [6:0] sync1_q;
  logic [6:0] sync2_q;
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else
    begin
      sync1_q <= {polarity_raw_i, main_above_start_i, main_above_stop_i,
                  rect_above_start_i, rect_above_stop_i,
                  comp_above_start_i, comp_above_stop_i};
      sync2_q <= sync1_q;
    end
  end
  logic pol_raw;
  logic m_start;
  logic m_stop;
  logic r_start;
  logic r_stop;
  logic c_start;
  logic c_stop;
  assign {pol_raw, m_start, m_stop, r_start, r_stop, c_start, c_stop}
    = sync2_q;

  // --------------------------------------------------------------
  // polarity filter and edge detect
  // --------------------------------------------------------------
  logic pol_filt;
  logic pol_prev_q;
  zcdg_polf #(
    .FILT_CYC(FILT_CYC)
  ) u_polf (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .raw_i(pol_raw),
    .filt_o(pol_filt)
  );
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      pol_prev_q <= 1'b0;
    else
      pol_prev_q <= pol_filt;
  end
  logic pol_rise;
  logic pol_fall;
  logic pol_edge;
  assign pol_rise = pol_filt && !pol_prev_q;
  assign pol_fall = !pol_filt && pol_prev_q;
  assign pol_edge = pol_rise || pol_fall;

  // a class may only enable once a polarity edge has been seen
  logic armed_q;
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      armed_q <= 1'b0;
    else if (pol_edge)
      armed_q <= 1'b1;
  end

  // --------------------------------------------------------------
  // hysteretic class enables
  // --------------------------------------------------------------
  // rectified magnitude flags serve both half cycles unchanged
  logic main_en;
  logic rect_en;
  logic comp_en;
  logic [2:0] st_vec;
  logic [2:0] sp_vec;
  logic [2:0] en_vec;
  assign st_vec = {c_start, r_start, m_start};
  assign sp_vec = {c_stop, r_stop, m_stop};
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_cls
      // each class judged on its own flags, so stops fall in any order
      zcdg_hyst u_hyst (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .clear_i(pol_edge || !armed_q),
        .above_start_i(st_vec[gi]),
        .above_stop_i(sp_vec[gi]),
        .enable_o(en_vec[gi])
      );
    end
  endgenerate
  assign main_en = en_vec[0];
  assign rect_en = en_vec[1];
  assign comp_en = en_vec[2];

  // --------------------------------------------------------------
  // open loop sequencer
  // --------------------------------------------------------------
  zcdg_pkg::zcdg_ol_e ol_q;
  logic [1:0] ol_idx_q;
  logic [`ZCDG_CNT_W-1:0] ol_cnt_q;
  logic ol_low_q;
  logic [`ZCDG_CNT_W-1:0] on_len;
  always_comb
  begin
    case (ol_idx_q)
      2'h0: on_len = `ZCDG_CNT_W'(`ZCDG_OL_ON0_US * UNIT_CYC);
      2'h1: on_len = `ZCDG_CNT_W'(`ZCDG_OL_ON1_US * UNIT_CYC);
      2'h2: on_len = `ZCDG_CNT_W'(`ZCDG_OL_ON2_US * UNIT_CYC);
      default: on_len = `ZCDG_CNT_W'(`ZCDG_OL_ON3_US * UNIT_CYC);
    endcase
  end
  logic [`ZCDG_CNT_W-1:0] off_len;
  // off time three times on time keeps each pulse at quarter duty
  assign off_len = `ZCDG_CNT_W'(on_len * `ZCDG_OL_OFF_MULT);
  logic ol_cnt_done;
  assign ol_cnt_done = (ol_q == zcdg_pkg::ZCDG_OL_ON)
    ? (ol_cnt_q == on_len - 1'b1) : (ol_cnt_q == off_len - 1'b1);

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      ol_q <= zcdg_pkg::ZCDG_OL_IDLE;
      ol_idx_q <= 2'h0;
      ol_cnt_q <= '0;
    end
    else if (pol_edge)
    begin
      ol_q <= zcdg_pkg::ZCDG_OL_ON;
      ol_idx_q <= 2'h0;
      ol_cnt_q <= '0;
    end
    else
    begin
      case (ol_q)
        zcdg_pkg::ZCDG_OL_IDLE:
          ol_cnt_q <= '0;
        zcdg_pkg::ZCDG_OL_ON:
          if (ol_cnt_done)
          begin
            ol_q <= zcdg_pkg::ZCDG_OL_OFF;
            ol_cnt_q <= '0;
          end
          else
            ol_cnt_q <= ol_cnt_q + 1'b1;
        zcdg_pkg::ZCDG_OL_OFF:
          if (ol_cnt_done)
          begin
            ol_cnt_q <= '0;
            if (ol_idx_q == 2'(`ZCDG_OL_PULSES - 1))
              ol_q <= zcdg_pkg::ZCDG_OL_IDLE;
            else
            begin
              ol_q <= zcdg_pkg::ZCDG_OL_ON;
              ol_idx_q <= ol_idx_q + 1'b1;
            end
          end
          else
            ol_cnt_q <= ol_cnt_q + 1'b1;
        default:
          ol_q <= zcdg_pkg::ZCDG_OL_IDLE;
      endcase
    end
  end

  // switch choice latched at the edge that starts the sequence
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      ol_low_q <= 1'b0;
    else if (pol_edge)
      ol_low_q <= pol_rise;
  end

  logic ol_busy;
  logic ol_pulse;
  assign ol_busy = (ol_q != zcdg_pkg::ZCDG_OL_IDLE);
  assign ol_pulse = (ol_q == zcdg_pkg::ZCDG_OL_ON);

  // --------------------------------------------------------------
  // drive outputs, all registered
  // --------------------------------------------------------------
  // positive half: low fast switch is duty controlled, high is sync,
  // low slow switch conducts; roles swap in the negative half
  logic pos;
  logic duty_ok;
  logic comp_ok;
  logic rect_ok;
  assign pos = pol_filt;
  // the edge cycle already shows the new polarity while enables are
  // still being cleared, so no drive may follow it in that cycle
  logic ol_hold;
  assign ol_hold = ol_busy || pol_edge;
  // stops below trips clear enables before the true crossing
  assign duty_ok = main_en && !ol_hold && duty_req_i;
  assign comp_ok = comp_en && !ol_hold && !duty_req_i;
  assign rect_ok = rect_en && !ol_hold;

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      fast_leg_low_drive_o <= 1'b0;
      fast_leg_high_drive_o <= 1'b0;
      fast_leg_low_sync_o <= 1'b0;
      fast_leg_high_sync_o <= 1'b0;
      slow_leg_low_switch_o <= 1'b0;
      slow_leg_high_switch_o <= 1'b0;
    end
    else
    begin
      fast_leg_low_drive_o <= (ol_pulse && ol_low_q)
        || (duty_ok && pos);
      fast_leg_high_drive_o <= (ol_pulse && !ol_low_q)
        || (duty_ok && !pos);
      fast_leg_high_sync_o <= comp_ok && pos;
      fast_leg_low_sync_o <= comp_ok && !pos;
      slow_leg_low_switch_o <= rect_ok && pos;
      slow_leg_high_switch_o <= rect_ok && !pos;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      sense_blank_o <= 1'b0;
      open_loop_busy_o <= 1'b0;
      positive_half_o <= 1'b0;
      multi_mode_o <= 1'b0;
    end
    else
    begin
      sense_blank_o <= ol_busy || pol_edge;
      open_loop_busy_o <= ol_busy || pol_edge;
      positive_half_o <= pol_filt;
      multi_mode_o <= (mode_multi_i == 1'(zcdg_pkg::ZCDG_MODE_MULTI));
    end
  end

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  // cycles since the last polarity edge, zero before the first one;
  // only the timing checks read it
  logic [`ZCDG_CHK_W-1:0] ol_age_q;
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      ol_age_q <= '0;
    else if (pol_edge)
      ol_age_q <= `ZCDG_CHK_W'(1);
    else if (ol_age_q != '0 && ol_age_q != '1)
      ol_age_q <= ol_age_q + 1'b1;
  end
  first_pulse_a : assert property (@(posedge clock_i) disable iff (rst_i)
    (ol_age_q != '0 && ol_age_q <= `ZCDG_CHK_W'(ON0_CYC))
      |-> ol_pulse)
    else $error("first open loop pulse too short");
  first_gap_a : assert property (@(posedge clock_i) disable iff (rst_i)
    (ol_age_q > `ZCDG_CHK_W'(ON0_CYC)
      && ol_age_q <= `ZCDG_CHK_W'(ON0_CYC + OFF0_CYC))
      |-> !ol_pulse)
    else $error("first open loop gap wrong");
  second_pulse_a : assert property (@(posedge clock_i) disable iff (rst_i)
    (ol_age_q == `ZCDG_CHK_W'(ON0_CYC + OFF0_CYC + 1))
      |-> ol_pulse)
    else $error("second open loop pulse late");
  ol_hold_a : assert property (@(posedge clock_i) disable iff (rst_i)
    ol_busy |=> !slow_leg_low_switch_o && !slow_leg_high_switch_o
      && !fast_leg_low_sync_o && !fast_leg_high_sync_o
      && sense_blank_o)
    else $error("slow or sync drive active during open loop");
  ol_side_a : assert property (@(posedge clock_i) disable iff (rst_i)
    (pol_rise ##1 ol_pulse) |=> fast_leg_low_drive_o
      && !fast_leg_high_drive_o)
    else $error("open loop pulse on wrong switch");
  ol_start_a : assert property (@(posedge clock_i) disable iff (rst_i)
    pol_edge |=> ol_busy)
    else $error("open loop sequence not started");
  main_gate_a : assert property (@(posedge clock_i) disable iff (rst_i)
    !main_en && !ol_busy |=> !fast_leg_low_drive_o
      && !fast_leg_high_drive_o)
    else $error("duty drive while disabled");
  no_overlap_a : assert property (@(posedge clock_i) disable iff (rst_i)
    !(fast_leg_low_drive_o && fast_leg_low_sync_o)
      && !(fast_leg_high_drive_o && fast_leg_high_sync_o))
    else $error("fast leg shoot through");
  seq_total_a : assert property (@(posedge clock_i) disable iff (rst_i)
    (ol_age_q == `ZCDG_CHK_W'(OL_TOTAL)) |-> ol_busy)
    else $error("open loop sequence ended early");
  seq_end_a : assert property (@(posedge clock_i) disable iff (rst_i)
    (ol_age_q == `ZCDG_CHK_W'(OL_TOTAL + 1)) |-> !ol_busy)
    else $error("open loop sequence ended late");
endmodule : zcdg_top

// ---- tb/zcdg_gate_model.sv ----
// Purpose: gate driver model of the totem pole power stage
// Assumes: drive outputs of zcdg_top, same clock
// Notes: records fast-leg pulse run lengths, flags cross conduction
`timescale 1ns/1ps
module zcdg_gate_model (
  input wire logic clock_i,
  input wire logic clear_i,
  input wire logic fl_lo_i,
  input wire logic fl_hi_i,
  input wire logic sy_lo_i,
  input wire logic sy_hi_i,
  input wire logic sl_lo_i,
  input wire logic sl_hi_i,
  output logic fault_o
);
  int on_q[$];
  int off_q[$];
  int run;
  logic last;
  logic cur;
  initial
  begin
    fault_o = 1'b0;
    run = 0;
    last = 1'b0;
  end
  always @(posedge clock_i)
  begin
    cur = fl_lo_i | fl_hi_i;
    if (clear_i)
    begin
      on_q.delete();
      off_q.delete();
      run = 0;
      last = 1'b0;
    end
    else if (cur !== last)
    begin
      // the low run before the first pulse is not a pulse gap
      if (last)
        on_q.push_back(run);
      else if (on_q.size() > 0)
        off_q.push_back(run);
      run = 1;
      last = cur;
    end
    else
      run++;
    // a leg with both switches on shorts the bulk rail
    if ((fl_lo_i & (fl_hi_i | sy_lo_i)) | (fl_hi_i & sy_hi_i)
        | (sy_lo_i & sy_hi_i) | (sl_lo_i & sl_hi_i))
      fault_o = 1'b1;
  end
endmodule : zcdg_gate_model

// ---- tb/test_zero_cross_drive_gating.sv ----
// Purpose: self-checking bench for zcdg_top
// Assumes: short polarity filter (1 us) to keep the run brief
// Notes: inputs change 2 ns after each rising edge
`timescale 1ns/1ps
`include "zcdg_defs.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_total++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module test_zero_cross_drive_gating;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic mode_multi_i = 1'b0;
  logic polarity_raw_i = 1'b0;
  logic [5:0] fl = 6'h3F;
  logic duty_req_i = 1'b0;
  logic clear = 1'b0;
  logic fll, flh, syl, syh, sll, slh, blank, pos, busy, mm, fault;
  int err_total = 0;
  int comparisons = 0;
  int cyc = 0;
  zcdg_top #(.POL_FILTER_US(1)) uut (.clock_i(clock_i), .rst_i(rst_i),
    .mode_multi_i(mode_multi_i), .polarity_raw_i(polarity_raw_i),
    .main_above_start_i(fl[0]), .main_above_stop_i(fl[1]),
    .rect_above_start_i(fl[2]), .rect_above_stop_i(fl[3]),
    .comp_above_start_i(fl[4]), .comp_above_stop_i(fl[5]),
    .duty_req_i(duty_req_i), .fast_leg_low_drive_o(fll),
    .fast_leg_high_drive_o(flh), .fast_leg_low_sync_o(syl),
    .fast_leg_high_sync_o(syh), .slow_leg_low_switch_o(sll),
    .slow_leg_high_switch_o(slh), .sense_blank_o(blank),
    .positive_half_o(pos), .open_loop_busy_o(busy), .multi_mode_o(mm));
  zcdg_gate_model gm (.clock_i(clock_i), .clear_i(clear), .fl_lo_i(fll),
    .fl_hi_i(flh), .sy_lo_i(syl), .sy_hi_i(syh), .sl_lo_i(sll),
    .sl_hi_i(slh), .fault_o(fault));
  // ----------------------------------------
  // clock, duty train and hang guard
  // ----------------------------------------
  initial
  begin
    forever #12.5 clock_i = ~clock_i;
  end
  always @(posedge clock_i)
  begin
    cyc++;
    #2 duty_req_i = cyc[1];
    if (cyc == 8000)
    begin
      err_total++;
      stop_test();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #2;
  endtask : tick
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test
  // ----------------------------------------
  // class observation and threshold walk
  // ----------------------------------------
  task automatic seen(input int k, output logic r);
    r = 1'b0;
    tick(6);
    repeat (8)
    begin
      tick(1);
      case (k)
        0: r |= pos ? fll : flh;
        1: r |= pos ? sll : slh;
        default: r |= pos ? syh : syl;
      endcase
    end
  endtask : seen
  task automatic class_test(input int k);
    logic r;
    fl[2*k +: 2] = 2'h3;
    seen(k, r);
    `CHK(r, 1'b1)
    fl[2*k +: 2] = 2'h2;
    seen(k, r);
    `CHK(r, 1'b1)
    fl[2*k +: 2] = 2'h0;
    seen(k, r);
    `CHK(r, 1'b0)
    fl[2*k +: 2] = 2'h2;
    seen(k, r);
    `CHK(r, 1'b0)
    fl[2*k +: 2] = 2'h3;
    seen(k, r);
    `CHK(r, 1'b1)
  endtask : class_test
  // ----------------------------------------
  // polarity edge and open loop sequence
  // ----------------------------------------
  task automatic edge_seq(input logic v);
    int us[4] = '{`ZCDG_OL_ON0_US, `ZCDG_OL_ON1_US, `ZCDG_OL_ON2_US,
      `ZCDG_OL_ON3_US};
    int n;
    int tot;
    clear = 1'b1;
    tick(1);
    clear = 1'b0;
    polarity_raw_i = v;
    n = 0;
    while (pos !== v && n < 100)
    begin
      tick(1);
      n++;
    end
    `CHK(pos, v)
    n = 0;
    while (blank !== 1'b1 && n < 3)
    begin
      tick(1);
      n++;
    end
    `CHK(blank, 1'b1)
    n = 0;
    while (blank === 1'b1 && n < 2200)
    begin
      `CHK(sll | slh | syl | syh, 1'b0)
      `CHK(v ? flh : fll, 1'b0)
      `CHK(busy, 1'b1)
      tick(1);
      n++;
    end
    tot = 0;
    for (int i = 0; i < 4; i++)
    begin
      tot += us[i] * `ZCDG_CLK_MHZ * (1 + `ZCDG_OL_OFF_MULT);
      `CHK(gm.on_q[i], us[i] * `ZCDG_CLK_MHZ)
      if (i < 3)
        `CHK(gm.off_q[i], us[i] * `ZCDG_CLK_MHZ * `ZCDG_OL_OFF_MULT)
    end
    // blanking also covers the edge cycle itself
    `CHK(n, tot + 1)
  endtask : edge_seq
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    tick(4);
    rst_i = 1'b0;
    tick(8);
    `CHK({fll, flh, syl, syh, sll, slh, blank}, 7'h00)
    mode_multi_i = 1'b1;
    tick(3);
    `CHK(mm, 1'b1)
    mode_multi_i = 1'b0;
    tick(3);
    `CHK(mm, 1'b0)
    polarity_raw_i = 1'b1;
    tick(20);
    polarity_raw_i = 1'b0;
    tick(60);
    `CHK(pos, 1'b0)
    edge_seq(1'b1);
    tick(8);
    `CHK(sll, 1'b1)
    for (int k = 0; k < 3; k++)
      class_test(k);
    fl = 6'h00;
    tick(8);
    `CHK({fll, flh, syl, syh, sll, slh}, 6'h00)
    edge_seq(1'b0);
    fl = 6'h3F;
    tick(8);
    `CHK(slh, 1'b1)
    for (int k = 0; k < 3; k++)
      class_test(k);
    `CHK(fault, 1'b0)
    stop_test();
  end
endmodule : test_zero_cross_drive_gating
